// ==== rst_pkg.sv ====
package rst_pkg;

    // ============================================================
    // Register map (APB byte addresses)
    localparam logic [7:0] ADDR_WDT_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SYS_CTRL = 8'h04;
    localparam logic [7:0] ADDR_VSEL = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;

    // ============================================================
    // Reset values and codes
    localparam logic [7:0] WDT_CTRL_RST = 8'h53;
    localparam logic [7:0] VSEL_RST = 8'h55;
    localparam logic [4:0] WDT_KEY_A = 5'h0A;
    localparam logic [4:0] WDT_KEY_B = 5'h15;
    localparam logic [7:0] VSEL_CODE_A = 8'h55;
    localparam logic [7:0] VSEL_CODE_B = 8'h33;
    localparam logic [7:0] VSEL_CODE_C = 8'h99;
    localparam logic [7:0] VSEL_CODE_D = 8'hAA;
    localparam logic [15:0] PORT_RST = 16'hFFFF;

    // ============================================================
    // Field positions
    localparam int WDT_KEY_LSB = 3;
    localparam int SC_IDLE_KEEP = 7;
    localparam int SC_SUPPLY_FLAG = 2;
    localparam int SC_VSEL_FLAG = 1;
    localparam int SC_KEY_FLAG = 0;

    // ============================================================
    // Timing
    localparam longint CLK_HZ = 200000000;
    localparam longint LS_DIV = 6250;
    localparam int FAULT_LS_CYCLES = 2;
    localparam longint DELAY_PWR_US = 50000;
    localparam longint DELAY_WDT_US = 16700;
    localparam longint DELAY_PWR_CYC = DELAY_PWR_US * (CLK_HZ / 1000000);
    localparam longint DELAY_WDT_CYC = DELAY_WDT_US * (CLK_HZ / 1000000);
    localparam longint LOWV_MIN_NS = 120000;
    localparam longint LOWV_MIN_CYC = (LOWV_MIN_NS * CLK_HZ + 999999999) / 1000000000;

    typedef enum logic [1:0] {
        RC_NONE,
        RC_FULL,
        RC_WDT
    } cause_t;

    typedef struct packed {
        logic clear_instr;
        logic halt_instr;
        logic low_power;
        logic power_down;
    } cpu_evt_t;

    typedef struct packed {
        logic core_reset;
        logic pc_sp_clear;
        logic [15:0] port_data;
        logic [15:0] port_dir;
    } rst_out_t;

endpackage : rst_pkg

// ==== lv_filter.sv ====
`timescale 1ns/1ps
module lv_filter
    import rst_pkg::*;
#(
    parameter int CYC = 24000
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Level in and qualified level out
    input wire logic level_in,
    output logic qual_out
);

    typedef struct packed {
        logic [31:0] cnt;
        logic q;
    } st_t;

    st_t s_q, s_d;

    always_comb begin
        s_d = s_q;
        if (!level_in) begin
            s_d.cnt = '0;
            s_d.q = 1'b0;
        end else if (s_q.cnt >= 32'(CYC)) begin
            s_d.q = 1'b1;
        end else begin
            s_d.cnt = s_q.cnt + 32'h1;
        end
    end

    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign qual_out = s_q.q;

endmodule : lv_filter

// ==== watchdog_and_reset_control.sv ====
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
// Contract
// - Watchdog runs only with a valid key
// - Bad key resets after 2-3 slow ticks
// - Running overflow: full reset, set timeout flag
// - Sleep overflow: timeout flag, clear PC/SP only
// - Key fault, clear, halt clear watchdog count
// - Power-on reset loads PC with zero
// - Power-on sets port data/direction all ones
// - Release delay 50 ms, or 16.7 ms
// - Low-voltage reset on outside power-down, sets flag
// - Short supply dips are ignored
// - Low-voltage reset off in power-down
// - Four voltage-select codes are valid
// - Bad select code resets and restores default
// - Real low-voltage reset keeps select register
// - Select fault flag set, software clears
// - Supply-drop flag set, software clears
// - Control bits 6 to 3 read zero
// - Running watchdog reset mirrors low-voltage reset
// - Key fault flag set, software clears
// - Period select picks 2^8 to 2^18
module watchdog_and_reset_control
    import rst_pkg::*;
#(
    parameter longint PWR_DELAY = DELAY_PWR_CYC,
    parameter longint WDT_DELAY = DELAY_WDT_CYC,
    parameter longint LOWV_MIN = LOWV_MIN_CYC,
    parameter longint SLOW_DIV = LS_DIV
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Core events and supply pin
    input wire cpu_evt_t cpu_evt,
    input wire logic low_supply_pin,
    // Reset outputs
    output rst_out_t rst_out,
    output logic timeout_flag,
    output logic power_down_flag
);

    // ============================================================
    // State
    typedef enum logic [1:0] {
        S_RUN,
        S_FAULT_WAIT,
        S_HOLD
    } phase_t;

    typedef struct packed {
        phase_t phase;
        logic [7:0] wdt_ctrl;
        logic [7:0] vsel;
        logic idle_keep;
        logic supply_flag;
        logic vsel_flag;
        logic key_flag;
        logic timeout;
        logic pdown;
        logic [18:0] wdt_cnt;
        logic [15:0] div_cnt;
        logic [1:0] fault_ticks;
        logic fault_is_vsel;
        logic [31:0] hold_cnt;
        cause_t cause;
        logic [31:0] rdata;
        logic ready;
        logic err;
        rst_out_t rout;
        logic [1:0] sup_sync;
    } st_t;

    st_t s_q, s_d;

    logic supply_low_qual;
    logic [18:0] wdt_limit;
    logic key_ok;
    logic vsel_ok;
    logic slow_tick;
    logic acc;
    logic wr;
    logic mapped;

    lv_filter #(
        .CYC(32'(LOWV_MIN))
    ) u_filter (
        .sys_clk(sys_clk),
        .reset(reset),
        .level_in(s_q.sup_sync[1]),
        .qual_out(supply_low_qual)
    );

    always_comb begin
        case (s_q.wdt_ctrl[2:0])
            3'h0: wdt_limit = 19'h00100;
            3'h1: wdt_limit = 19'h00400;
            3'h2: wdt_limit = 19'h01000;
            3'h3: wdt_limit = 19'h04000;
            3'h4: wdt_limit = 19'h08000;
            3'h5: wdt_limit = 19'h10000;
            3'h6: wdt_limit = 19'h20000;
            default: wdt_limit = 19'h40000;
        endcase
    end

    assign key_ok = (s_q.wdt_ctrl[7:WDT_KEY_LSB] == WDT_KEY_A) ||
                    (s_q.wdt_ctrl[7:WDT_KEY_LSB] == WDT_KEY_B);
    assign vsel_ok = (s_q.vsel == VSEL_CODE_A) || (s_q.vsel == VSEL_CODE_B) ||
                     (s_q.vsel == VSEL_CODE_C) || (s_q.vsel == VSEL_CODE_D);
    assign slow_tick = (s_q.div_cnt == 16'(SLOW_DIV - 1));
    assign acc = psel && penable;
    assign wr = acc && pwrite;
    assign mapped = (paddr == ADDR_WDT_CTRL) || (paddr == ADDR_SYS_CTRL) ||
                    (paddr == ADDR_VSEL) || (paddr == ADDR_STATUS);

    // ============================================================
    // Next state
    always_comb begin
        s_d = s_q;
        s_d.sup_sync = {s_q.sup_sync[0], low_supply_pin};
        s_d.div_cnt = slow_tick ? 16'h0 : s_q.div_cnt + 16'h1;
        s_d.ready = 1'b0;
        s_d.err = 1'b0;
        s_d.rout.pc_sp_clear = 1'b0;

        // Bus access
        if (psel && !penable) begin
            s_d.ready = 1'b1;
            s_d.err = !mapped;
            case (paddr)
                ADDR_WDT_CTRL: s_d.rdata = {24'h0, s_q.wdt_ctrl};
                ADDR_SYS_CTRL: s_d.rdata = {24'h0, s_q.idle_keep, 4'h0, s_q.supply_flag,
                                            s_q.vsel_flag, s_q.key_flag};
                ADDR_VSEL: s_d.rdata = {24'h0, s_q.vsel};
                ADDR_STATUS: s_d.rdata = {30'h0, s_q.timeout, s_q.pdown};
                default: s_d.rdata = 32'h0;
            endcase
        end
        if (wr && s_q.ready) begin
            case (paddr)
                ADDR_WDT_CTRL: s_d.wdt_ctrl = pwdata[7:0];
                ADDR_SYS_CTRL: begin
                    s_d.idle_keep = pwdata[SC_IDLE_KEEP];
                    s_d.supply_flag = s_q.supply_flag & pwdata[SC_SUPPLY_FLAG];
                    s_d.vsel_flag = s_q.vsel_flag & pwdata[SC_VSEL_FLAG];
                    s_d.key_flag = s_q.key_flag & pwdata[SC_KEY_FLAG];
                end
                ADDR_VSEL: s_d.vsel = pwdata[7:0];
                default: ;
            endcase
        end

        // Core instructions
        if (cpu_evt.clear_instr) begin
            s_d.wdt_cnt = '0;
            s_d.pdown = 1'b0;
            s_d.timeout = 1'b0;
        end
        if (cpu_evt.halt_instr) begin
            s_d.wdt_cnt = '0;
            s_d.pdown = 1'b1;
            s_d.timeout = 1'b0;
        end

        case (s_q.phase)
            S_RUN: begin
                if (key_ok && slow_tick && !cpu_evt.clear_instr && !cpu_evt.halt_instr) begin
                    s_d.wdt_cnt = s_q.wdt_cnt + 19'h1;
                end
                if (supply_low_qual && !cpu_evt.power_down) begin
                    s_d.supply_flag = 1'b1;
                    s_d.phase = S_HOLD;
                    s_d.cause = RC_FULL;
                    s_d.hold_cnt = '0;
                end else if (slow_tick && (!key_ok || !vsel_ok)) begin
                    s_d.phase = S_FAULT_WAIT;
                    s_d.fault_ticks = 2'h0;
                    s_d.fault_is_vsel = !vsel_ok;
                    if (!key_ok) begin
                        s_d.wdt_cnt = '0;
                    end
                end else if (key_ok && s_q.wdt_cnt >= wdt_limit) begin
                    s_d.wdt_cnt = '0;
                    s_d.timeout = 1'b1;
                    if (cpu_evt.low_power) begin
                        s_d.rout.pc_sp_clear = 1'b1;
                    end else begin
                        s_d.phase = S_HOLD;
                        s_d.cause = RC_WDT;
                        s_d.hold_cnt = '0;
                    end
                end
                if (!vsel_ok) begin
                    s_d.vsel_flag = 1'b1;
                end
            end
            S_FAULT_WAIT: begin
                if (!vsel_ok) begin
                    s_d.vsel_flag = 1'b1;
                end
                if (slow_tick) begin
                    s_d.fault_ticks = s_q.fault_ticks + 2'h1;
                    if (s_q.fault_ticks == 2'(FAULT_LS_CYCLES - 1)) begin
                        s_d.phase = S_HOLD;
                        s_d.cause = RC_FULL;
                        s_d.hold_cnt = '0;
                        if (s_q.fault_is_vsel) begin
                            s_d.vsel = VSEL_RST;
                        end else begin
                            s_d.key_flag = 1'b1;
                        end
                    end
                end
            end
            S_HOLD: begin
                s_d.rout.core_reset = 1'b1;
                s_d.rout.port_data = PORT_RST;
                s_d.rout.port_dir = PORT_RST;
                s_d.rout.pc_sp_clear = 1'b1;
                s_d.wdt_ctrl = WDT_CTRL_RST;
                s_d.wdt_cnt = '0;
                s_d.idle_keep = 1'b0;
                s_d.hold_cnt = s_q.hold_cnt + 32'h1;
                if (supply_low_qual) begin
                    s_d.hold_cnt = '0;
                end else if (s_q.hold_cnt >= 32'((s_q.cause == RC_WDT) ?
                                                 WDT_DELAY : PWR_DELAY)) begin
                    s_d.phase = S_RUN;
                    s_d.rout.core_reset = 1'b0;
                    s_d.cause = RC_NONE;
                end
            end
            default: s_d.phase = S_RUN;
        endcase
    end

    // ============================================================
    // Registers
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) begin
            s_q <= '0;
            s_q.phase <= S_HOLD;
            s_q.cause <= RC_FULL;
            s_q.wdt_ctrl <= WDT_CTRL_RST;
            s_q.vsel <= VSEL_RST;
            s_q.rout.core_reset <= 1'b1;
            s_q.rout.pc_sp_clear <= 1'b1;
            s_q.rout.port_data <= PORT_RST;
            s_q.rout.port_dir <= PORT_RST;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.rdata;
    assign pready = s_q.ready;
    assign pslverr = s_q.err;
    assign rst_out = s_q.rout;
    assign timeout_flag = s_q.timeout;
    assign power_down_flag = s_q.pdown;

endmodule : watchdog_and_reset_control

// ==== watchdog_and_reset_control_asserts.sv ====
`timescale 1ns/1ps
module watchdog_and_reset_control_asserts
    import rst_pkg::*;
#(
    parameter longint WDT_DELAY = 50
) (
    // Clock and reset
    input wire logic sys_clk,
    input wire logic reset,
    // Register bus
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Core side
    input wire cpu_evt_t cpu_evt,
    input wire rst_out_t rst_out,
    input wire logic timeout_flag,
    input wire logic power_down_flag
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (reset);
    // ============================================================
    // Length of the current internal reset hold
    logic [31:0] hold_q;
    logic [31:0] hold_d;
    always_comb hold_d = rst_out.core_reset ? hold_q + 32'h1 : 32'h0;
    always_ff @(posedge sys_clk or posedge reset) begin
        if (reset) hold_q <= 32'h0;
        else hold_q <= hold_d;
    end
    // ============================================================
    // Properties
    property p_ready;
        psel && !penable |=> pready;
    endproperty
    a_ready: assert property (p_ready) else $error("no answer after setup");
    property p_err;
        pready && paddr > ADDR_STATUS |-> pslverr;
    endproperty
    a_err: assert property (p_err) else $error("unmapped access not refused");
    property p_ok;
        pready && paddr == ADDR_VSEL |-> !pslverr;
    endproperty
    a_ok: assert property (p_ok) else $error("mapped access refused");
    property p_rsv;
        pready && !pwrite && paddr == ADDR_SYS_CTRL |-> prdata[6:3] == 4'h0;
    endproperty
    a_rsv: assert property (p_rsv) else $error("reserved bits not zero");
    property p_port;
        rst_out.core_reset && $past(rst_out.core_reset) |->
            rst_out.port_data == PORT_RST && rst_out.port_dir == PORT_RST;
    endproperty
    a_port: assert property (p_port) else $error("ports not all ones");
    property p_pc;
        rst_out.core_reset && $past(rst_out.core_reset) |-> rst_out.pc_sp_clear;
    endproperty
    a_pc: assert property (p_pc) else $error("counter not held at zero");
    property p_hold;
        $fell(rst_out.core_reset) |-> hold_q >= WDT_DELAY - 1;
    endproperty
    a_hold: assert property (p_hold) else $error("reset hold too short");
    property p_to;
        $rose(timeout_flag) && !cpu_evt.low_power |-> ##[0:3] rst_out.core_reset;
    endproperty
    a_to: assert property (p_to) else $error("overflow gave no reset");
    property p_sleep;
        $rose(timeout_flag) && cpu_evt.low_power |-> (!rst_out.core_reset) [*4];
    endproperty
    a_sleep: assert property (p_sleep) else $error("sleep overflow reset");
    property p_halt;
        cpu_evt.halt_instr && !rst_out.core_reset |->
            ##[1:2] (power_down_flag && !timeout_flag);
    endproperty
    a_halt: assert property (p_halt) else $error("halt flags wrong");
    property p_clr;
        cpu_evt.clear_instr && !cpu_evt.halt_instr && !rst_out.core_reset |->
            ##[1:2] !power_down_flag;
    endproperty
    a_clr: assert property (p_clr) else $error("clear left flag");
endmodule : watchdog_and_reset_control_asserts

// ==== test_watchdog_and_reset_control.sv ====
`timescale 1ns/1ps
module test_watchdog_and_reset_control
    import rst_pkg::*;
;
    localparam longint PD = 100;
    localparam longint WD = 50;
    localparam longint LM = 10;
    localparam longint SD = 4;
    logic sys_clk, reset, psel, penable, pwrite, pready, pslverr, er;
    logic low_supply_pin, timeout_flag, power_down_flag;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    cpu_evt_t cpu_evt;
    rst_out_t rst_out;
    int mismatches, checks, n;
    watchdog_and_reset_control #(.PWR_DELAY(PD), .WDT_DELAY(WD), .LOWV_MIN(LM),
        .SLOW_DIV(SD)) dut (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .cpu_evt, .low_supply_pin, .rst_out,
        .timeout_flag, .power_down_flag);
    initial begin
        sys_clk = 1'b0;
        forever #2.5 sys_clk = ~sys_clk;
    end
    // ============================================================
    // Shared tasks
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        checks++;
        if (s !== e) begin
            mismatches++;
            $display("MISMATCH t=%0t seen %h want %h", $time, s, e);
        end
    endtask : chk
    task automatic cyc(input int c);
        repeat (c) @(posedge sys_clk);
    endtask : cyc
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        // Only the bench watchdog ends a wait for a slave that never answers
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask : apb
    task automatic rdchk(input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask : rdchk
    // Cycles until core_reset, or pc_sp_clear, reaches level v
    task automatic until_cr(input logic v, input int lim, input bit pc = 0);
        n = 0;
        while ((pc ? rst_out.pc_sp_clear : rst_out.core_reset) !== v && n < lim) begin
            @(posedge sys_clk);
            n++;
        end
    endtask : until_cr
    task automatic pulse(input logic h);
        cpu_evt.halt_instr <= h;
        cpu_evt.clear_instr <= !h;
        @(posedge sys_clk);
        cpu_evt.halt_instr <= 1'b0;
        cpu_evt.clear_instr <= 1'b0;
        cyc(1);
    endtask : pulse
    task automatic dip(input int len);
        low_supply_pin <= 1'b1;
        cyc(len);
        low_supply_pin <= 1'b0;
        cyc(60);
    endtask : dip
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : give_verdict
    // ============================================================
    // Scenarios
    task automatic t_por();
        chk(rst_out.pc_sp_clear, 1'b1);
        chk({rst_out.port_data, rst_out.port_dir}, {PORT_RST, PORT_RST});
        until_cr(1'b0, 1000);
        chk(32'(n >= PD - 2 && n <= PD + 4), 1);
        rdchk(ADDR_WDT_CTRL, 32'(WDT_CTRL_RST));
        rdchk(ADDR_VSEL, 32'(VSEL_RST));
        rdchk(ADDR_SYS_CTRL, 32'h0);
        rdchk(8'h10, 32'h0);
        chk(er, 1'b1);
        $display("power-on test done");
    endtask : t_por
    task automatic t_codes();
        logic [7:0] c [4] = '{VSEL_CODE_A, VSEL_CODE_B, VSEL_CODE_C, VSEL_CODE_D};
        foreach (c[i]) begin
            apb(1'b1, ADDR_VSEL, 32'(c[i]));
            cyc(40);
            rdchk(ADDR_VSEL, 32'(c[i]));
            chk(rst_out.core_reset, 1'b0);
        end
        $display("select code test done");
    endtask : t_codes
    task automatic t_fault(input logic [7:0] a, input logic [7:0] bad,
        input logic [7:0] rv, input logic [7:0] fl);
        apb(1'b1, a, 32'(bad));
        until_cr(1'b1, 40);
        chk(32'(n >= 2 * SD - 2 && n <= 4 * SD + 4), 1);
        until_cr(1'b0, 1000);
        chk(32'(n >= PD - 2 && n <= PD + 4), 1);
        rdchk(a, 32'(rv));
        rdchk(ADDR_SYS_CTRL, 32'(fl));
        apb(1'b1, ADDR_SYS_CTRL, 32'h0);
        rdchk(ADDR_SYS_CTRL, 32'h0);
        $display("fault test done");
    endtask : t_fault
    task automatic t_lowv();
        apb(1'b1, ADDR_VSEL, 32'(VSEL_CODE_B));
        dip(int'(LM) - 4);
        chk(rst_out.core_reset, 1'b0);
        cpu_evt.power_down <= 1'b1;
        dip(int'(LM) + 20);
        chk(rst_out.core_reset, 1'b0);
        cpu_evt.power_down <= 1'b0;
        dip(int'(LM) + 20);
        chk(rst_out.core_reset, 1'b1);
        until_cr(1'b0, 1000);
        rdchk(ADDR_VSEL, 32'(VSEL_CODE_B));
        rdchk(ADDR_SYS_CTRL, 32'h4);
        apb(1'b1, ADDR_SYS_CTRL, 32'h0);
        rdchk(ADDR_SYS_CTRL, 32'h0);
        apb(1'b1, ADDR_SYS_CTRL, 32'hFF);
        rdchk(ADDR_SYS_CTRL, 32'h80);
        $display("low voltage test done");
    endtask : t_lowv
    task automatic t_wdt();
        apb(1'b1, ADDR_WDT_CTRL, 32'h50);
        repeat (3) begin
            cyc(600);
            pulse(1'b0);
        end
        chk(rst_out.core_reset, 1'b0);
        until_cr(1'b1, 1300);
        chk(32'(n >= 1024 - 2 * SD && n <= 1024 + 4 * SD + 4), 1);
        chk(timeout_flag, 1'b1);
        until_cr(1'b0, 1000);
        chk(32'(n >= WD - 2 && n <= WD + 4), 1);
        rdchk(ADDR_STATUS, 32'h2);
        rdchk(ADDR_WDT_CTRL, 32'(WDT_CTRL_RST));
        $display("watchdog run test done");
    endtask : t_wdt
    task automatic t_sleep();
        apb(1'b1, ADDR_WDT_CTRL, 32'h50);
        cpu_evt.low_power <= 1'b1;
        pulse(1'b1);
        chk({timeout_flag, power_down_flag}, 2'b01);
        until_cr(1'b1, 1300, 1);
        chk(32'(n < 1300), 1);
        cyc(2);
        chk({rst_out.core_reset, timeout_flag, power_down_flag}, 3'b011);
        cpu_evt.low_power <= 1'b0;
        pulse(1'b0);
        chk({timeout_flag, power_down_flag}, 2'b00);
        $display("sleep test done");
    endtask : t_sleep
    // ============================================================
    // Main sequence and watchdog
    initial begin
        reset = 1'b1;
        {psel, penable, pwrite, paddr, pwdata} = '0;
        cpu_evt = '0;
        low_supply_pin = 1'b0;
        mismatches = 0;
        checks = 0;
        repeat (4) @(posedge sys_clk);
        reset <= 1'b0;
        t_por();
        t_codes();
        t_fault(ADDR_VSEL, 8'h12, VSEL_RST, 8'h02);
        t_fault(ADDR_WDT_CTRL, 8'h03, WDT_CTRL_RST, 8'h01);
        t_lowv();
        t_wdt();
        t_sleep();
        give_verdict();
    end
    initial begin
        repeat (30000) @(posedge sys_clk);
        mismatches++;
        $display("MISMATCH t=%0t run did not finish", $time);
        give_verdict();
    end
endmodule : test_watchdog_and_reset_control
bind watchdog_and_reset_control watchdog_and_reset_control_asserts #(.WDT_DELAY(WDT_DELAY))
    u_chk (.sys_clk, .reset, .psel, .penable, .pwrite, .paddr, .prdata, .pready, .pslverr,
    .cpu_evt, .rst_out, .timeout_flag, .power_down_flag);
